// >>> design/strobe_edge_sync.v
// two-flop synchroniser for the bus pins plus write-strobe rising edge detect
// assumes pins are asynchronous to clk; edge taken from the second flop onward
`timescale 1ns/1ps

module strobe_edge_sync #(
    parameter DW = 8
) (
    input  wire          clk,
    input  wire          sys_rst,
    input  wire          write_strobe_n,
    input  wire          cmd_data_select,
    input  wire [DW-1:0] data_in,
    output reg           write_rise,
    output reg           sel_out,
    output reg  [DW-1:0] data_out
);
    // =========================================================
    // synchroniser stages
    reg          wr_s1_q;
    reg          wr_s2_q;
    reg          wr_s3_q;
    reg          sel_s1_q;
    reg          sel_s2_q;
    reg [DW-1:0] dat_s1_q;
    reg [DW-1:0] dat_s2_q;

    always @(posedge clk) begin
        if (sys_rst) begin
            wr_s1_q    <= 1'b1;
            wr_s2_q    <= 1'b1;
            wr_s3_q    <= 1'b1;
            sel_s1_q   <= 1'b0;
            sel_s2_q   <= 1'b0;
            dat_s1_q   <= {DW{1'b0}};
            dat_s2_q   <= {DW{1'b0}};
            write_rise <= 1'b0;
            sel_out    <= 1'b0;
            data_out   <= {DW{1'b0}};
        end else begin
            wr_s1_q    <= write_strobe_n;
            wr_s2_q    <= wr_s1_q;
            wr_s3_q    <= wr_s2_q;
            sel_s1_q   <= cmd_data_select;
            sel_s2_q   <= sel_s1_q;
            dat_s1_q   <= data_in;
            dat_s2_q   <= dat_s1_q;
            // data and select pass through every cycle, delayed to line up with the strobe edge
            write_rise <= wr_s2_q & ~wr_s3_q;
            sel_out    <= sel_s2_q;
            data_out   <= dat_s2_q;
        end
    end
endmodule // strobe_edge_sync

// >>> design/tear_scan_consts.vh
// command codes, mode-word field positions and reset values for the
// tear sync / scan order command interpreter
`ifndef TEAR_SCAN_CONSTS_VH
`define TEAR_SCAN_CONSTS_VH

`define CMD_TEAR_OFF        8'h34
`define CMD_TEAR_ON         8'h35
`define CMD_ADDR_MODE       8'h36

`define MODE_RESET          8'h00
`define MODE_PAGE_ORDER     7
`define MODE_COL_ORDER      6
`define MODE_EXCHANGE       5
`define MODE_LINE_ORDER     4
`define MODE_BGR            3
`define MODE_LATCH_ORDER    2
`define MODE_HFLIP          1
`define MODE_VFLIP          0

`define BLANK_SEL_BIT       0

`endif

// >>> design/tear_sync_and_scan_order.v
// command interpreter for tear sync on/off and the scan order mode word
// assumes a host on the parallel display bus; panel timing comes in as
// vblank/hblank levels on clk; sleep and soft reset come from other decoders
//
// Contract
// - tear-off command stops sync pulse output
// - tear-off when already off changes nothing
// - tear-on takes one byte, bit0 selects
// - select 0 vblank only, 1 adds hblank
// - tear-on when already on is ignored
// - sync timing ignores line refresh order bit
// - sleep holds sync output low
// - address-mode command loads eight-bit mode word; the code holds latch-order bit2 at zero
// - mode load touches only mode word
// - bit7 page order top/bottom
// - bit6 column order left/right
// - bit5 swaps page and column roles
// - bit4 panel refresh line order
// - bit3 selects rgb or bgr order
// - bit1 horizontal flip
// - bit0 vertical flip
// - commands accepted in every power state
`timescale 1ns/1ps
`include "tear_scan_consts.vh"

module tear_sync_and_scan_order #(
    parameter DW = 8
) (
    input  wire          clk,
    input  wire          sys_rst,
    input  wire          soft_reset,
    input  wire          write_strobe_n,
    input  wire          read_strobe_n,
    input  wire          chip_select_n,
    input  wire          cmd_data_select,
    input  wire [DW-1:0] data_in,
    input  wire          sleep_in,
    input  wire          vblank,
    input  wire          hblank,
    output reg           frame_sync_pulse,
    output reg           sync_enabled,
    output reg           blank_line_select,
    output reg           page_order,
    output reg           col_order,
    output reg           page_col_swap,
    output reg           line_order,
    output reg           bgr_order,
    output reg           hflip,
    output reg           vflip
);
    // =========================================================
    // decoder states
    localparam ST_IDLE    = 2'b00;
    localparam ST_TE_PARM = 2'b01;
    localparam ST_AM_PARM = 2'b10;

    // =========================================================
    // pin synchronisation
    wire          wr_rise;
    wire          sel_s;
    wire [DW-1:0] dat_s;
    reg           cs_s1_q;
    reg           cs_s2_q;
    reg           slp_s1_q;
    reg           slp_s2_q;
    reg           vb_s1_q;
    reg           vb_s2_q;
    reg           hb_s1_q;
    reg           hb_s2_q;

    // read strobe is not used: none of these commands return data
    strobe_edge_sync #(.DW(DW)) u_sync (
        .clk             (clk),
        .sys_rst         (sys_rst),
        .write_strobe_n  (write_strobe_n),
        .cmd_data_select (cmd_data_select),
        .data_in         (data_in),
        .write_rise      (wr_rise),
        .sel_out         (sel_s),
        .data_out        (dat_s)
    );

    always @(posedge clk) begin
        if (sys_rst) begin
            cs_s1_q  <= 1'b1;
            cs_s2_q  <= 1'b1;
            slp_s1_q <= 1'b0;
            slp_s2_q <= 1'b0;
            vb_s1_q  <= 1'b0;
            vb_s2_q  <= 1'b0;
            hb_s1_q  <= 1'b0;
            hb_s2_q  <= 1'b0;
        end else begin
            cs_s1_q  <= chip_select_n;
            cs_s2_q  <= cs_s1_q;
            slp_s1_q <= sleep_in;
            slp_s2_q <= slp_s1_q;
            vb_s1_q  <= vblank;
            vb_s2_q  <= vb_s1_q;
            hb_s1_q  <= hblank;
            hb_s2_q  <= hb_s1_q;
        end
    end

    // =========================================================
    // command decode
    // cs is sampled one cycle after the strobe edge; host must hold cs across the edge
    reg  [1:0] state_q;
    reg  [1:0] state_d;
    reg        sync_en_q;
    reg        sync_en_d;
    reg        blank_sel_q;
    reg        blank_sel_d;
    reg  [7:0] mode_q;
    reg  [7:0] mode_d;
    wire       byte_in = wr_rise & ~cs_s2_q;
    wire       is_cmd  = byte_in & ~sel_s;
    wire       is_par  = byte_in &  sel_s;

    function is_code;
        input [DW-1:0] b;
        input [7:0]    code;
        begin
            is_code = (b[7:0] == code);
        end
    endfunction

    always @* begin
        state_d     = state_q;
        sync_en_d   = sync_en_q;
        blank_sel_d = blank_sel_q;
        mode_d      = mode_q;
        // no gating by sleep or display mode: every state accepts these
        if (is_cmd) begin
            state_d = ST_IDLE;
            if (is_code(dat_s, `CMD_TEAR_OFF)) begin
                sync_en_d = 1'b0;
            end else if (is_code(dat_s, `CMD_TEAR_ON)) begin
                state_d = ST_TE_PARM;
            end else if (is_code(dat_s, `CMD_ADDR_MODE)) begin
                state_d = ST_AM_PARM;
            end
        end else if (is_par) begin
            case (state_q)
                ST_TE_PARM: begin
                    // already on: the parameter is dropped, mode kept
                    if (!sync_en_q) begin
                        sync_en_d   = 1'b1;
                        blank_sel_d = dat_s[`BLANK_SEL_BIT];
                    end
                    state_d = ST_IDLE;
                end
                ST_AM_PARM: begin
                    // only the mode word changes
                    mode_d  = dat_s[7:0];
                    // unsupported latch-order bit kept at zero
                    mode_d[`MODE_LATCH_ORDER] = 1'b0;
                    state_d = ST_IDLE;
                end
                default: begin
                    state_d = ST_IDLE;
                end
            endcase
        end
    end

    // soft reset restores sync defaults; mode word keeps its value
    always @(posedge clk) begin
        if (sys_rst) begin
            state_q     <= ST_IDLE;
            sync_en_q   <= 1'b0;
            blank_sel_q <= 1'b0;
            mode_q      <= `MODE_RESET;
        end else if (soft_reset) begin
            state_q     <= ST_IDLE;
            sync_en_q   <= 1'b0;
            blank_sel_q <= 1'b0;
        end else begin
            state_q     <= state_d;
            sync_en_q   <= sync_en_d;
            blank_sel_q <= blank_sel_d;
            mode_q      <= mode_d;
        end
    end

    // =========================================================
    // sync output and mode fields
    // pulse is built from blanking levels only; line order never enters
    reg sync_d;

    always @* begin
        if (slp_s2_q) begin
            sync_d = 1'b0;
        end else if (!sync_en_q) begin
            sync_d = 1'b0;
        end else if (blank_sel_q) begin
            sync_d = vb_s2_q | hb_s2_q;
        end else begin
            sync_d = vb_s2_q;
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            frame_sync_pulse  <= 1'b0;
            sync_enabled      <= 1'b0;
            blank_line_select <= 1'b0;
            page_order        <= 1'b0;
            col_order         <= 1'b0;
            page_col_swap     <= 1'b0;
            line_order        <= 1'b0;
            bgr_order         <= 1'b0;
            hflip             <= 1'b0;
            vflip             <= 1'b0;
        end else begin
            frame_sync_pulse  <= sync_d;
            sync_enabled      <= sync_en_q;
            blank_line_select <= blank_sel_q;
            page_order        <= mode_q[`MODE_PAGE_ORDER];
            col_order         <= mode_q[`MODE_COL_ORDER];
            page_col_swap     <= mode_q[`MODE_EXCHANGE];
            line_order        <= mode_q[`MODE_LINE_ORDER];
            bgr_order         <= mode_q[`MODE_BGR];
            hflip             <= mode_q[`MODE_HFLIP];
            vflip             <= mode_q[`MODE_VFLIP];
        end
    end
endmodule // tear_sync_and_scan_order

// >>> verification/tear_host_model.sv
// host side of the display bus: one task sends a command or parameter byte
// assumes the caller waits out the interpreter latency between commands
`timescale 1ns/1ps
module tear_host_model (
    input  wire       clk,
    output reg        write_strobe_n,
    output reg        read_strobe_n,
    output reg        chip_select_n,
    output reg        cmd_data_select,
    output reg  [7:0] data_in
);
// ==========
// byte transfer
initial begin
    write_strobe_n = 1'b1;
    read_strobe_n = 1'b1;
    chip_select_n = 1'b1;
    cmd_data_select = 1'b1;
    data_in = 8'h00;
end
task send(input sel, input [7:0] b);
    begin
        @(negedge clk);
        chip_select_n = 1'b0;
        cmd_data_select = sel;
        data_in = b;
        @(negedge clk);
        write_strobe_n = 1'b0;
        repeat (4) @(negedge clk);
        write_strobe_n = 1'b1;
        repeat (2) @(negedge clk);
        chip_select_n = 1'b1;
        // bus has no pull, so a released line must not keep its last value
        cmd_data_select = ~sel;
        data_in = ~b;
        repeat (3) @(negedge clk);
    end
endtask
endmodule // tear_host_model

// >>> verification/tear_scan_chk_sva.sv
// assertions for the tear sync / scan order interpreter
// bound to the top module; sees its ports only
`timescale 1ns/1ps
module tear_scan_chk #(parameter DW = 8) (
    input wire          clk,
    input wire          sys_rst,
    input wire          soft_reset,
    input wire          write_strobe_n,
    input wire          read_strobe_n,
    input wire          chip_select_n,
    input wire          cmd_data_select,
    input wire [DW-1:0] data_in,
    input wire          sleep_in,
    input wire          vblank,
    input wire          hblank,
    input wire          frame_sync_pulse,
    input wire          sync_enabled,
    input wire          blank_line_select,
    input wire          page_order,
    input wire          col_order,
    input wire          page_col_swap,
    input wire          line_order,
    input wire          bgr_order,
    input wire          hflip,
    input wire          vflip
);
// ==========
// age of the last strobe rise, mode view
reg        wr_q;
reg  [3:0] age_q;
wire [6:0] mode_w = {page_order, col_order, page_col_swap, line_order, bgr_order, hflip, vflip};
always @(posedge clk) begin
    wr_q <= write_strobe_n;
    if (sys_rst)
        age_q <= 4'hf;
    else if (write_strobe_n && !wr_q)
        age_q <= 4'h0;
    else if (age_q != 4'hf)
        age_q <= age_q + 4'h1;
end
default clocking cb @(posedge clk); endclocking
default disable iff (sys_rst);
// the off and blank checks look one cycle back so the output flag matches the internal state
a_sleep_low: assert property (
    sleep_in [*4] |-> !frame_sync_pulse) else $error("sync active in sleep");
a_off_low: assert property (
    !sync_enabled [*5] |-> !$past(frame_sync_pulse)) else $error("sync active when off");
a_vblank_only: assert property (
    (sync_enabled && !blank_line_select && !sleep_in) [*5]
    |-> $past(frame_sync_pulse) == $past(vblank, 4)) else $error("sync not vblank");
a_both_blanks: assert property (
    (sync_enabled && blank_line_select && !sleep_in) [*5]
    |-> $past(frame_sync_pulse) == ($past(vblank, 4) || $past(hblank, 4)))
    else $error("sync not vblank or hblank");
a_mode_caused: assert property (
    $changed(mode_w) |-> age_q <= 4'h8) else $error("mode changed without write");
a_on_keeps_sel: assert property (
    sync_enabled && $past(sync_enabled) |-> $stable(blank_line_select))
    else $error("select changed while on");
a_reset_clear: assert property (
    $past(sys_rst) |-> !sync_enabled && !blank_line_select && mode_w == 7'h00)
    else $error("state not cleared by reset");
a_soft_off: assert property (
    soft_reset |-> ##[1:3] !sync_enabled) else $error("soft reset left sync on");
c_sleep_on: cover property (sync_enabled && sleep_in && vblank);
c_mode_load: cover property ($changed(mode_w));
c_hblank_pulse: cover property (frame_sync_pulse && blank_line_select && !vblank);
endmodule // tear_scan_chk
bind tear_sync_and_scan_order tear_scan_chk #(.DW(DW)) i_chk (
    .clk, .sys_rst, .soft_reset, .write_strobe_n, .read_strobe_n, .chip_select_n,
    .cmd_data_select, .data_in, .sleep_in, .vblank, .hblank, .frame_sync_pulse,
    .sync_enabled, .blank_line_select, .page_order, .col_order, .page_col_swap,
    .line_order, .bgr_order, .hflip, .vflip);

// >>> verification/tear_sync_and_scan_order_tb.sv
// bench for the tear sync / scan order interpreter against a small model
// host model drives the bus; blank and sleep levels come from here
`timescale 1ns/1ps
`include "tear_scan_consts.vh"
module tear_sync_and_scan_order_tb;
// ==========
// signals, instances, compares
reg        clk, sys_rst, soft_reset, sleep_in, vblank, hblank;
wire       write_strobe_n, read_strobe_n, chip_select_n, cmd_data_select;
wire [7:0] data_in;
wire       frame_sync_pulse, sync_enabled, blank_line_select, page_order, col_order;
wire       page_col_swap, line_order, bgr_order, hflip, vflip;
integer    errors = 0, comparisons = 0, cycles = 0, seed = 20, i, m_en = 0, m_sel = 0, m_mode = 0;
tear_host_model i_host (.clk, .write_strobe_n, .read_strobe_n, .chip_select_n,
    .cmd_data_select, .data_in);
tear_sync_and_scan_order #(.DW(8)) i_dut (.clk, .sys_rst, .soft_reset, .write_strobe_n,
    .read_strobe_n, .chip_select_n, .cmd_data_select, .data_in, .sleep_in, .vblank,
    .hblank, .frame_sync_pulse, .sync_enabled, .blank_line_select, .page_order,
    .col_order, .page_col_swap, .line_order, .bgr_order, .hflip, .vflip);
initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
end
task conclude;
    begin
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
endtask
always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
        errors = errors + 1;
        conclude;
    end
end
task tally(input [9:0] got, input [9:0] exp);
    begin
        comparisons = comparisons + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    end
endtask
task chk_state;
    tally({sync_enabled, blank_line_select, page_order, col_order, page_col_swap,
        line_order, bgr_order, 1'b0, hflip, vflip}, {m_en[0], m_sel[0], m_mode[7:0]});
endtask
task chk_pulse(input e);
    tally({9'h000, frame_sync_pulse}, {9'h000, e});
endtask
task gap(input integer n);
    repeat (n) @(negedge clk);
endtask
task cmd(input [7:0] c, input integer np, input [7:0] p);
    begin
        i_host.send(1'b0, c);
        if (np)
            i_host.send(1'b1, p);
        if (c == `CMD_TEAR_OFF)
            m_en = 0;
        if (c == `CMD_TEAR_ON && np && m_en == 0) begin
            m_en = 1;
            m_sel = p[`BLANK_SEL_BIT];
        end
        if (c == `CMD_ADDR_MODE && np)
            m_mode = p;
        gap(8);
    end
endtask
// ==========
// main sequence
initial begin
    sys_rst = 1'b1;
    soft_reset = 1'b0;
    sleep_in = 1'b0;
    vblank = 1'b0;
    hblank = 1'b0;
    gap(6);
    sys_rst = 1'b0;
    chk_state;
    cmd(`CMD_TEAR_OFF, 0, 8'h00);
    chk_state;
    cmd(`CMD_TEAR_ON, 1, 8'hff);
    chk_state;
    hblank = 1'b1;
    gap(5);
    chk_pulse(1'b1);
    cmd(`CMD_TEAR_ON, 1, 8'h00);
    chk_state;
    for (i = 0; i < 8; i = i + 1) begin
        cmd(`CMD_ADDR_MODE, 1, $random(seed) & 8'hfb);
        chk_state;
        chk_pulse(1'b1);
    end
    cmd(`CMD_TEAR_OFF, 0, 8'h00);
    vblank = 1'b1;
    gap(5);
    chk_pulse(1'b0);
    cmd(`CMD_TEAR_ON, 1, 8'h00);
    chk_pulse(1'b1);
    vblank = 1'b0;
    gap(5);
    chk_pulse(1'b0);
    sleep_in = 1'b1;
    vblank = 1'b1;
    cmd(`CMD_TEAR_OFF, 0, 8'h00);
    chk_state;
    cmd(`CMD_TEAR_ON, 1, 8'h01);
    cmd(`CMD_ADDR_MODE, 1, 8'ha1);
    chk_state;
    chk_pulse(1'b0);
    sleep_in = 1'b0;
    cmd(8'h33, 1, 8'h5a);
    i_host.send(1'b1, 8'h12);
    gap(8);
    chk_state;
    soft_reset = 1'b1;
    gap(1);
    soft_reset = 1'b0;
    m_en = 0;
    m_sel = 0;
    gap(8);
    chk_state;
    // hardware reset in mid-run clears the mode word that soft reset kept
    sys_rst = 1'b1;
    gap(6);
    sys_rst = 1'b0;
    m_mode = 0;
    chk_state;
    cmd(`CMD_ADDR_MODE, 1, 8'h5b);
    chk_state;
    conclude;
end
endmodule // tear_sync_and_scan_order_tb
